// file: beat_buffer.sv
`timescale 1ns/1ns
module beat_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    // Filling side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Draining side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
    logic [AW:0] count_r, count_nxt;
    logic push, pop;

    assign in_ready_out = count_r != (AW + 1)'(DEPTH);
    assign out_valid_out = count_r != '0;
    assign out_data_out = mem_r[rd_r];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        mem_nxt = mem_r;
        rd_nxt = rd_r;
        wr_nxt = wr_r;
        if (push) begin
            mem_nxt[wr_r] = in_data_in;
            wr_nxt = (wr_r == LAST) ? '0 : wr_r + AW'(1);
        end
        if (pop) begin
            rd_nxt = (rd_r == LAST) ? '0 : rd_r + AW'(1);
        end
        count_nxt = count_r + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            rd_r <= '0;
            wr_r <= '0;
            count_r <= '0;
        end else begin
            mem_r <= mem_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            count_r <= count_nxt;
        end
    end
endmodule

// file: pr_host_model.sv
`timescale 1ns/1ns
module pr_host_model (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    // Pacing chosen by the bench
    input wire logic slow_in,
    // Command side
    output logic cdb_valid_out,
    input wire logic cdb_ready_in,
    output pr_report_pkg::cdb_type cdb_out,
    // Data side
    input wire logic data_valid_in,
    output logic data_ready_out,
    input wire logic [7:0] data_in
);
    import pr_report_pkg::*;
    logic [7:0] rx_q[$];
    logic [1:0] pace_r;
    initial begin
        cdb_valid_out = 1'b0;
        cdb_out = '0;
        data_ready_out = 1'b0;
        pace_r = 2'h0;
    end
    // Slow pacing takes one byte in four, so the two-entry buffer fills up
    always @(posedge clk_sys_in) begin
        if (arst_n_in && data_valid_in && data_ready_out) begin
            rx_q.push_back(data_in);
        end
        pace_r <= pace_r + 2'h1;
        data_ready_out <= arst_n_in && (!slow_in || pace_r == 2'h0);
    end
    // Held until taken; afterwards the bus shows the inverse, never a stale copy
    task automatic issue(input cdb_type c);
        cdb_valid_out <= 1'b1;
        cdb_out <= c;
        do @(posedge clk_sys_in); while (cdb_ready_in !== 1'b1);
        cdb_valid_out <= 1'b0;
        cdb_out <= ~c;
    endtask
endmodule

// file: pr_report_cfg.svh
`ifndef PR_REPORT_CFG_SVH
`define PR_REPORT_CFG_SVH

// Command decode
`define PRI_OPCODE 8'h5e
`define PRI_SA_KEYS 5'h00
`define PRI_SA_RESV 5'h01
`define PRI_SA_CAPS 5'h02
`define PRI_SA_FULL 5'h03

// Reservation-change actions that advance the generation
`define PRO_SA_REGISTER 5'h00
`define PRO_SA_CLEAR 5'h03
`define PRO_SA_PREEMPT 5'h04
`define PRO_SA_PREEMPT_ABORT 5'h05

// Reservation type codes
`define RTYPE_WR_EX 4'h1
`define RTYPE_EX_AC 4'h3
`define RTYPE_WR_EX_RO 4'h5
`define RTYPE_EX_AC_RO 4'h6

// Layout of the returned data
`define HDR_LAST_IDX 16'h0007
`define KEY_DESC_BYTES 16'h0008
`define RESV_DESC_BYTES 16'h0010
`define FULL_DESC_BYTES 16'h0018
`define CAPS_LEN 16'h0008
`define CAPS_FLAGS 16'h0080
`define CAPS_TYPE_MASK 16'h6a00

// Reset values and sense data
`define GEN_RESET 32'h0000_0000
`define SENSE_ILLEGAL 4'h5
`define ASC_INVALID_CDB 8'h24
`define ASCQ_INVALID_CDB 8'h00

`endif

// file: pr_report_pkg.sv
package pr_report_pkg;

    typedef struct packed {
        logic [7:0] opcode;
        logic [2:0] rsvd1;
        logic [4:0] action;
        logic [39:0] rsvd2;
        logic [15:0] alloc_len;
        logic [7:0] control;
    } cdb_type;

    typedef struct packed {
        logic check;
        logic [3:0] sense_key;
        logic [7:0] asc;
        logic [7:0] ascq;
    } status_type;

    typedef struct packed {
        logic [4:0] action;
        logic ok;
    } pro_event_type;

    typedef struct packed {
        logic present;
        logic [63:0] key;
        logic [31:0] scope_addr;
        logic [3:0] scope;
        logic [3:0] rtype;
    } resv_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR = 2'b01,
        ST_BODY = 2'b10,
        ST_END = 2'b11
    } state_type;

endpackage

// file: reservation_report_responder.sv
// Notes on behaviour
// - Opcode 5Eh is the report command; service action is byte 1 low bits.
// - Allocation length sits in bytes 7-8, MSB first; transfer never exceeds it.
// - Actions 00h keys, 01h reservations, 02h capabilities, 03h full status.
// - Actions 04h-1Fh end with check condition, illegal request, invalid field.
// - A 32-bit generation counts register, clear, preempt, preempt-and-abort requests.
// - Reports, reserve, release and failed changes leave the generation unchanged.
// - Power-on and hard reset clear the generation whatever the persistence setting.
// - Key-list additional length is the full list size, never truncated.
// - Short allocation sends bytes from 0 up to it, drops the rest, no error.
// - Key list holds one 8-byte key per registered initiator, all ports.
// - Reservation data carries the same generation; its length ignores truncation.
// - Exactly one descriptor when a reservation exists, otherwise none.
// - Each descriptor reports the scope set when the reservation was made.
// - Change actions advancing generation: 00h, 03h, 04h and 05h.
// - Reported types: 1h, 3h, 5h and 6h.
`timescale 1ns/1ns
`include "pr_report_cfg.svh"
module reservation_report_responder #(
    parameter int SLOTS = 4,
    parameter int SLOT_W = (SLOTS > 1) ? $clog2(SLOTS) : 1
) (
    // Clock and resets
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic hard_reset_in,
    // Command descriptor block
    input wire logic cdb_valid_in,
    output logic cdb_ready_out,
    input wire pr_report_pkg::cdb_type cdb_in,
    // Completed reservation-change commands
    input wire logic pro_done_in,
    input wire pr_report_pkg::pro_event_type pro_in,
    // Registration table and current reservation
    input wire logic [SLOTS-1:0] reg_valid_in,
    input wire logic [SLOTS-1:0][63:0] reg_keys_in,
    input wire pr_report_pkg::resv_type resv_in,
    // Parameter data stream
    output logic data_valid_out,
    input wire logic data_ready_in,
    output logic [7:0] data_out,
    // Completion
    output logic status_valid_out,
    output pr_report_pkg::status_type status_out,
    output logic busy_out,
    output logic [31:0] generation_out
);
    import pr_report_pkg::*;

    localparam int CW = $clog2(SLOTS + 1);

    state_type state_r, state_nxt;
    logic [4:0] sa_r, sa_nxt;
    logic [15:0] idx_r, idx_nxt;
    logic [SLOT_W-1:0] slot_r, slot_nxt;
    logic [15:0] sent_r, sent_nxt;
    logic [15:0] limit_r, limit_nxt;
    logic [31:0] gen_r, gen_nxt;
    logic [31:0] gen_snap_r, gen_snap_nxt;
    logic [31:0] addl_r, addl_nxt;
    logic check_r, check_nxt;
    status_type status_r, status_nxt;
    logic status_vld_r, status_vld_nxt;

    logic cdb_take, gen_bump, push, buf_ready, buf_valid;
    logic entry_here, last_slot;
    logic [7:0] push_byte;
    logic [15:0] entry_len, sent_inc;
    logic [63:0] cur_key;
    logic [CW-1:0] reg_count;
    logic [SLOTS-1:0] holder_vec;

    // Byte i of a 64-bit word, counted from the most significant end
    function automatic logic [7:0] pick8(input logic [63:0] v, input logic [2:0] i);
        logic [63:0] s;
        s = v << {i, 3'b000};
        pick8 = s[63:56];
    endfunction

    assign cdb_ready_out = state_r == ST_IDLE;
    assign cdb_take = cdb_valid_in && cdb_ready_out;
    assign busy_out = state_r != ST_IDLE;
    assign status_valid_out = status_vld_r;
    assign status_out = status_r;
    assign generation_out = gen_r;
    assign sent_inc = sent_r + 16'h0001;

    // Failed or conflicting changes are filtered out by the ok flag
    assign gen_bump = pro_done_in && pro_in.ok &&
        (pro_in.action == `PRO_SA_REGISTER || pro_in.action == `PRO_SA_CLEAR ||
        pro_in.action == `PRO_SA_PREEMPT || pro_in.action == `PRO_SA_PREEMPT_ABORT);

    always_comb begin
        if (hard_reset_in) begin
            gen_nxt = `GEN_RESET;
        end else if (gen_bump) begin
            gen_nxt = gen_r + 32'h0000_0001;
        end else begin
            gen_nxt = gen_r;
        end
    end

    always_comb begin
        reg_count = '0;
        for (int i = 0; i < SLOTS; i++) begin
            reg_count = reg_count + CW'(reg_valid_in[i]);
        end
    end

    // A registrant holds the reservation when its key matches the holder's key
    for (genvar g = 0; g < SLOTS; g++) begin : g_holder
        assign holder_vec[g] = resv_in.present && reg_valid_in[g] &&
            reg_keys_in[g] == resv_in.key;
    end

    always_comb begin
        if (sa_r == `PRI_SA_KEYS) begin
            entry_len = `KEY_DESC_BYTES;
        end else if (sa_r == `PRI_SA_RESV) begin
            entry_len = `RESV_DESC_BYTES;
        end else begin
            entry_len = `FULL_DESC_BYTES;
        end
    end

    // Slots are walked in index order, skipping empty ones
    assign entry_here = (sa_r == `PRI_SA_RESV) ?
        (resv_in.present && slot_r == '0) : reg_valid_in[slot_r];
    assign last_slot = (sa_r == `PRI_SA_RESV) || slot_r == SLOT_W'(SLOTS - 1);
    assign cur_key = (sa_r == `PRI_SA_RESV) ? resv_in.key : reg_keys_in[slot_r];
    assign push = buf_ready &&
        (state_r == ST_HDR || (state_r == ST_BODY && entry_here));

    always_comb begin
        push_byte = 8'h00;
        if (state_r == ST_HDR) begin
            if (sa_r == `PRI_SA_CAPS) begin
                push_byte = pick8({`CAPS_LEN, `CAPS_FLAGS, `CAPS_TYPE_MASK, 16'h0000},
                    idx_r[2:0]);
            end else begin
                push_byte = pick8({gen_snap_r, addl_r}, idx_r[2:0]);
            end
        end else if (idx_r < 16'h0008) begin
            push_byte = pick8(cur_key, idx_r[2:0]);
        end else if (sa_r == `PRI_SA_RESV) begin
            if (idx_r < 16'h000c) begin
                push_byte = pick8({resv_in.scope_addr, 32'h0000_0000},
                    {1'b0, idx_r[1:0]});
            end else if (idx_r == 16'h000d) begin
                push_byte = {resv_in.scope, resv_in.rtype};
            end
        end else if (idx_r == 16'h000c) begin
            push_byte = {7'h00, holder_vec[slot_r]};
        end else if (idx_r == 16'h000d && holder_vec[slot_r]) begin
            push_byte = {resv_in.scope, resv_in.rtype};
        end
    end

    always_comb begin
        state_nxt = state_r;
        sa_nxt = sa_r;
        idx_nxt = idx_r;
        slot_nxt = slot_r;
        sent_nxt = sent_r;
        limit_nxt = limit_r;
        gen_snap_nxt = gen_snap_r;
        addl_nxt = addl_r;
        check_nxt = check_r;
        status_nxt = status_r;
        status_vld_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (cdb_take && cdb_in.opcode == `PRI_OPCODE) begin
                    sa_nxt = cdb_in.action;
                    idx_nxt = '0;
                    slot_nxt = '0;
                    sent_nxt = '0;
                    limit_nxt = cdb_in.alloc_len;
                    gen_snap_nxt = gen_r;
                    if (cdb_in.action == `PRI_SA_KEYS) begin
                        addl_nxt = 32'({reg_count, 3'b000});
                    end else if (cdb_in.action == `PRI_SA_RESV) begin
                        addl_nxt = resv_in.present ? 32'(`RESV_DESC_BYTES) : '0;
                    end else begin
                        addl_nxt = 32'(reg_count) * 32'(`FULL_DESC_BYTES);
                    end
                    if (cdb_in.action > `PRI_SA_FULL) begin
                        check_nxt = 1'b1;
                        state_nxt = ST_END;
                    end else begin
                        check_nxt = 1'b0;
                        state_nxt = (cdb_in.alloc_len == '0) ? ST_END : ST_HDR;
                    end
                end
            end
            ST_HDR: begin
                if (push) begin
                    sent_nxt = sent_inc;
                    idx_nxt = idx_r + 16'h0001;
                    if (sent_inc == limit_r) begin
                        state_nxt = ST_END;
                    end else if (idx_r == `HDR_LAST_IDX) begin
                        idx_nxt = '0;
                        state_nxt = (sa_r == `PRI_SA_CAPS) ? ST_END : ST_BODY;
                    end
                end
            end
            ST_BODY: begin
                if (!entry_here) begin
                    if (last_slot) begin
                        state_nxt = ST_END;
                    end else begin
                        slot_nxt = slot_r + SLOT_W'(1);
                    end
                end else if (push) begin
                    sent_nxt = sent_inc;
                    idx_nxt = idx_r + 16'h0001;
                    if (sent_inc == limit_r) begin
                        state_nxt = ST_END;
                    end else if (idx_r == entry_len - 16'h0001) begin
                        idx_nxt = '0;
                        if (last_slot) begin
                            state_nxt = ST_END;
                        end else begin
                            slot_nxt = slot_r + SLOT_W'(1);
                        end
                    end
                end
            end
            ST_END: begin
                // Status waits until the last byte has left the buffer
                if (!buf_valid) begin
                    status_vld_nxt = 1'b1;
                    if (check_r) begin
                        status_nxt = {1'b1, `SENSE_ILLEGAL, `ASC_INVALID_CDB,
                            `ASCQ_INVALID_CDB};
                    end else begin
                        status_nxt = '0;
                    end
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_r <= ST_IDLE;
            sa_r <= '0;
            idx_r <= '0;
            slot_r <= '0;
            sent_r <= '0;
            limit_r <= '0;
            gen_r <= `GEN_RESET;
            gen_snap_r <= `GEN_RESET;
            addl_r <= '0;
            check_r <= 1'b0;
            status_r <= '0;
            status_vld_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sa_r <= sa_nxt;
            idx_r <= idx_nxt;
            slot_r <= slot_nxt;
            sent_r <= sent_nxt;
            limit_r <= limit_nxt;
            gen_r <= gen_nxt;
            gen_snap_r <= gen_snap_nxt;
            addl_r <= addl_nxt;
            check_r <= check_nxt;
            status_r <= status_nxt;
            status_vld_r <= status_vld_nxt;
        end
    end

    // Two entries absorb a receiver stall without losing a byte
    beat_buffer #(
        .WIDTH(8),
        .DEPTH(2)
    ) u_buffer (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .in_valid_in(push),
        .in_ready_out(buf_ready),
        .in_data_in(push_byte),
        .out_valid_out(buf_valid),
        .out_ready_in(data_ready_in),
        .out_data_out(data_out)
    );
    assign data_valid_out = buf_valid;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence s_bad_cmd;
        cdb_take && cdb_in.opcode == `PRI_OPCODE && cdb_in.action > `PRI_SA_FULL;
    endsequence
    sequence s_check_status;
        status_vld_r && status_r.check && status_r.sense_key == `SENSE_ILLEGAL &&
            status_r.asc == `ASC_INVALID_CDB;
    endsequence

    chk_bad_action: assert property (
        s_bad_cmd |-> ##[1:4] s_check_status)
        else $error("reserved service action not ended with check condition");
    chk_gen_bump: assert property (
        gen_bump && !hard_reset_in |=> gen_r == $past(gen_r) + 32'h0000_0001)
        else $error("generation did not advance on a counted change");
    chk_gen_steady: assert property (
        !gen_bump && !hard_reset_in |=> $stable(gen_r))
        else $error("generation moved without a counted change");
    chk_gen_clear: assert property (
        hard_reset_in |=> gen_r == `GEN_RESET)
        else $error("hard reset did not clear generation");
    chk_alloc_bound: assert property (
        push |-> sent_r < limit_r)
        else $error("byte sent beyond allocation length");
    chk_sent_total: assert property (
        state_r != ST_IDLE |-> sent_r <= limit_r)
        else $error("transfer count exceeds allocation length");
    chk_foreign_op: assert property (
        cdb_take && cdb_in.opcode != `PRI_OPCODE |=> state_r == ST_IDLE && !status_vld_r)
        else $error("foreign opcode was acted on");
    chk_key_len: assert property (
        cdb_take && cdb_in.opcode == `PRI_OPCODE && cdb_in.action == `PRI_SA_KEYS
        |=> addl_r == 32'({$past(reg_count), 3'b000}))
        else $error("key list length not the full list size");
    chk_one_desc: assert property (
        push && state_r == ST_BODY && sa_r == `PRI_SA_RESV |-> slot_r == '0 && resv_in.present)
        else $error("reservation descriptor emitted without a reservation");
    chk_gen_first: assert property (
        push && state_r == ST_HDR && sa_r != `PRI_SA_CAPS && idx_r == '0
        |-> push_byte == gen_snap_r[31:24])
        else $error("generation not sent most significant byte first");
endmodule

// file: reservation_report_responder_tb_top.sv
`timescale 1ns/1ns
`include "pr_report_cfg.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("Error at %0t ns: got %0h expected %0h", $time, (got), (exp)); end end
module reservation_report_responder_tb_top;
    import pr_report_pkg::*;
    logic clk_sys_in, arst_n_in, hard_rst, cdb_valid, cdb_ready, pro_done, slow;
    logic data_valid, data_ready, status_valid, busy;
    logic [7:0] data;
    logic [31:0] generation, exp_gen;
    logic [3:0] reg_valid;
    logic [3:0][63:0] reg_keys;
    cdb_type cdb_bus;
    pro_event_type pro;
    resv_type resv;
    status_type status;
    logic [7:0] exp_q[$];
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;

    reservation_report_responder #(.SLOTS(4)) dut_u (
        .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .hard_reset_in(hard_rst),
        .cdb_valid_in(cdb_valid), .cdb_ready_out(cdb_ready), .cdb_in(cdb_bus),
        .pro_done_in(pro_done), .pro_in(pro), .reg_valid_in(reg_valid),
        .reg_keys_in(reg_keys), .resv_in(resv), .data_valid_out(data_valid),
        .data_ready_in(data_ready), .data_out(data), .status_valid_out(status_valid),
        .status_out(status), .busy_out(busy), .generation_out(generation));

    pr_host_model host_u (
        .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .slow_in(slow),
        .cdb_valid_out(cdb_valid), .cdb_ready_in(cdb_ready), .cdb_out(cdb_bus),
        .data_valid_in(data_valid), .data_ready_out(data_ready), .data_in(data));

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // A hang in any handshake ends here rather than running forever
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic put(input logic [63:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) exp_q.push_back(v[8*i +: 8]);
    endtask

    task automatic build(input logic [4:0] sa);
        int n;
        logic h;
        n = 0;
        exp_q = {};
        for (int s = 0; s < 4; s++) n += int'(reg_valid[s]);
        case (sa)
            5'h00: begin
                put(exp_gen, 4);
                put(64'(8 * n), 4);
                for (int s = 0; s < 4; s++) if (reg_valid[s]) put(reg_keys[s], 8);
            end
            5'h01: begin
                put(exp_gen, 4);
                put(resv.present ? 64'h10 : 64'h0, 4);
                if (resv.present) begin
                    put(resv.key, 8);
                    put(resv.scope_addr, 4);
                    put(64'h0, 1);
                    put({resv.scope, resv.rtype}, 1);
                    put(64'h0, 2);
                end
            end
            5'h02: begin
                put(`CAPS_LEN, 2);
                put(`CAPS_FLAGS, 2);
                put(`CAPS_TYPE_MASK, 2);
                put(64'h0, 2);
            end
            default: begin
                put(exp_gen, 4);
                put(64'(24 * n), 4);
                for (int s = 0; s < 4; s++) begin
                    h = resv.present && reg_keys[s] == resv.key;
                    if (reg_valid[s]) begin
                        put(reg_keys[s], 8);
                        put(64'h0, 4);
                        put(h, 1);
                        put(h ? {resv.scope, resv.rtype} : 8'h0, 1);
                        put(64'h0, 10);
                    end
                end
            end
        endcase
    endtask

    task automatic run(input logic [7:0] op, input logic [4:0] sa, input logic [15:0] alen);
        cdb_type c;
        int i;
        c = '0;
        c.opcode = op;
        c.action = sa;
        c.alloc_len = alen;
        @(posedge clk_sys_in);
        host_u.rx_q = {};
        build(sa);
        while (exp_q.size() > int'(alen)) void'(exp_q.pop_back());
        if (sa > 5'h03 || op != `PRI_OPCODE) exp_q = {};
        host_u.issue(c);
        i = 0;
        if (op != `PRI_OPCODE) begin
            repeat (20) @(posedge clk_sys_in) if (status_valid === 1'b1) i++;
            `CHK(i, 0)
        end else begin
            @(posedge clk_sys_in);
            `CHK(busy, 1'b1)
            while (status_valid !== 1'b1 && i < 2000) begin
                @(posedge clk_sys_in);
                i++;
            end
            `CHK(status_valid, 1'b1)
            `CHK(busy, 1'b0)
            `CHK(status, (sa > 5'h03) ? {1'b1, `SENSE_ILLEGAL, `ASC_INVALID_CDB,
                `ASCQ_INVALID_CDB} : 21'h0)
        end
        `CHK(host_u.rx_q.size(), exp_q.size())
        foreach (exp_q[k]) `CHK(host_u.rx_q[k], exp_q[k])
        $display("Test done: op %h action %h length %h", op, sa, alen);
    endtask

    task automatic change(input logic [4:0] a, input logic ok, input logic hr);
        @(posedge clk_sys_in);
        pro_done <= 1'b1;
        pro <= {a, ok};
        hard_rst <= hr;
        if (ok && a inside {`PRO_SA_REGISTER, `PRO_SA_CLEAR, `PRO_SA_PREEMPT,
            `PRO_SA_PREEMPT_ABORT}) exp_gen++;
        if (hr) exp_gen = '0;
        @(posedge clk_sys_in);
        pro_done <= 1'b0;
        hard_rst <= 1'b0;
        @(posedge clk_sys_in);
        `CHK(generation, exp_gen)
    endtask

    logic [5:0] events[10] = '{6'h01, 6'h03, 6'h05, 6'h07, 6'h09, 6'h0b, 6'h0d, 6'h00,
        6'h08, 6'h07};
    logic [3:0] rtypes[4] = '{`RTYPE_WR_EX, `RTYPE_EX_AC, `RTYPE_WR_EX_RO, `RTYPE_EX_AC_RO};

    initial begin
        arst_n_in = 1'b0;
        hard_rst = 1'b0;
        pro_done = 1'b0;
        pro = '0;
        slow = 1'b0;
        reg_valid = 4'b0101;
        reg_keys = {64'h4d4c_4b4a_4948_4746, 64'h3938_3736_3534_3332,
            64'h2f2e_2d2c_2b2a_2928, 64'h1716_1514_1312_1110};
        resv = '0;
        exp_gen = '0;
        repeat (5) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        `CHK(generation, 32'h0)
        run(8'h5e, 5'h00, 16'h0100);
        foreach (events[i]) change(events[i][5:1], events[i][0], 1'b0);
        foreach (rtypes[i]) begin
            resv <= '{1'b1, reg_keys[2], 32'h0a0b_0c0d, 4'h0, rtypes[i]};
            run(8'h5e, 5'h01, 16'h0040);
        end
        resv.present <= 1'b0;
        run(8'h5e, 5'h01, 16'h0040);
        run(8'h5e, 5'h00, 16'h000b);
        slow <= 1'b1;
        run(8'h5e, 5'h00, 16'hffff);
        run(8'h5e, 5'h02, 16'h0040);
        reg_valid <= 4'hf;
        resv.present <= 1'b1;
        run(8'h5e, 5'h03, 16'h0100);
        slow <= 1'b0;
        run(8'h5e, 5'h00, 16'h0000);
        for (int sa = 4; sa < 32; sa++) run(8'h5e, 5'(sa), 16'h0040);
        run(8'h5f, 5'h00, 16'h0040);
        change(5'h00, 1'b1, 1'b1);
        run(8'h5e, 5'h00, 16'h0100);
        tally_and_finish();
    end
endmodule
